// File: bench/ipmi_command_watchdog_tb_top.sv
// self-checking bench for the command watchdog
`timescale 1ns/1ps
`default_nettype none
module ipmi_command_watchdog_tb_top;
  import wdc_pkg::*;
  localparam int TK = 20;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  wdc_byte_t req;
  wdc_byte_t rsp;
  logic ready, running, hard, down, cyc, logx, smi, nmi, msg;
  logic [4:0] flags;
  logic [8:0] exp_q [$];
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] seed = 32'd48;
  wire logic [2:0] pre_v = {msg, nmi, smi};
  wire logic [2:0] act_v = {cyc, down, hard};
  always #2.5 clk_in = ~clk_in;
  // short step count keeps the run brief
  wdc_watchdog #(.TICK_CYCLES(TK)) uut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .req_ready_out(ready), .rsp_out(rsp), .running_out(running), .hard_reset_out(hard),
    .power_down_out(down), .power_cycle_out(cyc), .log_expiry_out(logx), .pre_smi_out(smi),
    .pre_nmi_out(nmi), .pre_msg_out(msg), .expire_flags_out(flags));
  wdc_host host (.clk_in(clk_in), .ready_in(ready), .req_out(req));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_lvl(input logic [8:0] got, input logic [8:0] want);
    checks_done++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic cmp_rsp(input logic [8:0] got, input logic [8:0] want);
    cmp_lvl(got, want);
  endtask
  // hang guard, far above the expected run length
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  // each response byte meets the oldest note; an unexpected byte never matches x
  always @(negedge clk_in) begin
    if (rsp.valid === 1'b1) begin
      cmp_rsp({rsp.last, rsp.data}, exp_q.size() > 0 ? exp_q.pop_front() : 9'hxxx);
    end
  end
  // note the answer, send the request, wait for the answer to drain
  task automatic cmd(input int rn, input logic [71:0] r, input int an, input logic [71:0] a);
    int i;
    for (i = 0; i < an; i++) exp_q.push_back({i == an - 1, a[71 - 8 * i -: 8]});
    host.send(rn, r);
    for (i = 0; i < 50 && exp_q.size() > 0; i++) @(negedge clk_in);
    // an answer that never came is a miss, not silence; drop it so later notes stay aligned
    cmp_lvl(9'(exp_q.size()), 9'h000);
    exp_q.delete();
  endtask
  task automatic wait_hit(input bit act, input logic [2:0] want, input int lim);
    int i;
    for (i = 0; i < lim && (act ? act_v : pre_v) !== want; i++) @(negedge clk_in);
    cmp_lvl({6'h0, act ? act_v : pre_v}, {6'h0, want});
  endtask
  initial begin
    int k;
    int c;
    logic [7:0] u;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    cmd(2, {8'h18, 8'h30, 56'h0}, 1, {8'hc1, 64'h0});
    cmd(3, {8'h18, 8'h22, 8'h00, 48'h0}, 1, {8'hc7, 64'h0});
    cmd(2, {8'h18, 8'h25, 56'h0}, 9, 72'h0);
    // per pass: pre type k, action k, use 2k-1, random count just above 1 s
    for (k = 1; k <= 3; k++) begin
      seed = xs(seed);
      c = 11 + seed[1:0];
      u = 8'(2 * k - 1);
      cmd(8, {8'h18, 8'h24, u, 1'b0, k[2:0], 1'b0, k[2:0], 8'h01, 8'h3e, c[7:0], 16'h0},
        1, 72'h0);
      cmp_lvl({3'h0, running, flags}, {3'h0, 1'b1, 5'h0});
      cmd(2, {8'h18, 8'h25, 56'h0}, 9, {8'h00, u, 1'b0, k[2:0], 1'b0, k[2:0], 8'h01,
        8'h00, c[7:0], 8'h00, c[7:0], 8'h00});
      wait_hit(1'b0, 3'b1 << (k - 1), 100);
      cmd(2, {8'h18, 8'h22, 56'h0}, 1, 72'h0);
      cmp_lvl({5'h0, running, pre_v}, 9'h008);
      wait_hit(1'b0, 3'b1 << (k - 1), 100);
      // keep running with a fresh count; the second pass also stops logging
      cmd(8, {8'h18, 8'h24, (k == 2), 1'b1, 3'h0, u[2:0], 1'b0, k[2:0], 1'b0, k[2:0], 8'h01,
        8'h00, c[7:0], 16'h0}, 1, 72'h0);
      cmp_lvl({5'h0, running, pre_v}, 9'h008);
      wait_hit(1'b1, 3'b1 << (k - 1), c * TK + 20);
      cmp_lvl({8'h0, logx}, {8'h0, (k != 2)});
      @(negedge clk_in);
      cmp_lvl({3'h0, running, flags}, {3'h0, 1'b0, 5'h1 << (u - 1)});
    end
    // a no-stop set on a stopped timer loads the count but leaves it stopped
    cmd(8, {8'h18, 8'h24, 8'h41, 8'h00, 8'h01, 8'h00, 8'h05, 16'h0}, 1, 72'h0);
    cmd(2, {8'h18, 8'h25, 56'h0}, 9, {8'h00, 8'h41, 8'h00, 8'h01, 8'h20, 8'h05, 8'h00,
      8'h05, 8'h00});
    repeat (10 * TK) @(negedge clk_in);
    cmp_lvl({8'h0, running}, 9'h0);
    give_verdict();
  end
endmodule // ipmi_command_watchdog_tb_top
`default_nettype wire

// File: bench/wdc_host.sv
// host side: sends watchdog requests as byte streams
`timescale 1ns/1ps
`default_nettype none
module wdc_host (
  input wire logic clk_in,
  input wire logic ready_in,
  output var wdc_pkg::wdc_byte_t req_out
);
  import wdc_pkg::*;
  initial req_out = '0;
  // one request, bytes msb-first in v; each byte held until the edge that takes it
  task automatic send(input int n, input logic [71:0] v);
    int i;
    @(posedge clk_in);
    for (i = 0; i < n; i++) begin
      req_out <= '{valid: 1'b1, last: (i == n - 1), data: v[71 - 8 * i -: 8]};
      do @(negedge clk_in); while (ready_in !== 1'b1);
      @(posedge clk_in);
    end
    // released data is inverted so a stale byte never repeats
    req_out <= '{valid: 1'b0, last: 1'b0, data: ~v[79 - 8 * n -: 8]};
  endtask
endmodule // wdc_host
`default_nettype wire

// File: hdl/wdc_map.svh
// constants for the command-driven system watchdog
`ifndef WDC_MAP_SVH
`define WDC_MAP_SVH
// request header codes
`define WDC_NETFN_APP 8'h18
`define WDC_CMD_RELOAD 8'h22
`define WDC_CMD_SET 8'h24
`define WDC_CMD_GET 8'h25
// completion codes
`define WDC_CC_OK 8'h00
`define WDC_CC_BAD_CMD 8'hc1
`define WDC_CC_BAD_LEN 8'hc7
// request lengths in bytes, header included
`define WDC_LEN_RELOAD 4'h2
`define WDC_LEN_SET 4'h8
`define WDC_LEN_GET 4'h2
`define WDC_LEN_MAX 4'h9
// response lengths
`define WDC_RSP_SHORT 4'h1
`define WDC_RSP_GET 4'h9
// set request byte positions
`define WDC_B_USE 2
`define WDC_B_ACT 3
`define WDC_B_PRE 4
`define WDC_B_CLR 5
`define WDC_B_LO 6
`define WDC_B_HI 7
// field positions
`define WDC_F_NOLOG 7
`define WDC_F_NOSTOP 6
`define WDC_F_PRE_HI 6
`define WDC_F_PRE_LO 4
`define WDC_F_CLR_HI 5
`define WDC_F_CLR_LO 1
// use, interrupt and action codes
`define WDC_USE_MIN 3'h1
`define WDC_USE_MAX 3'h5
`define WDC_PRE_SMI 3'h1
`define WDC_PRE_NMI 3'h2
`define WDC_PRE_MSG 3'h3
`define WDC_ACT_HARD 3'h1
`define WDC_ACT_DOWN 3'h2
`define WDC_ACT_CYCLE 3'h3
// reset values
`define WDC_INIT_RST 16'h0000
`define WDC_PRE_RST 8'h00
// timing: one count is 100 ms at 200 MHz
`define WDC_TICK_MS 100
`define WDC_CLK_MHZ 200
`define WDC_TICK_CYC (`WDC_TICK_MS * 1000 * `WDC_CLK_MHZ)
`define WDC_TICKS_PER_S (1000 / `WDC_TICK_MS)
`endif

// File: hdl/wdc_pkg.sv
// types shared by the watchdog files
`default_nettype none
package wdc_pkg;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } wdc_byte_t;
  typedef struct packed {
    logic no_log;
    logic no_stop;
    logic [2:0] use_code;
    logic [2:0] pre_irq;
    logic [2:0] action;
    logic [7:0] pre_secs;
    logic [15:0] init;
  } wdc_cfg_t;
  typedef enum logic [1:0] {
    WDC_ST_RX = 2'b00,
    WDC_ST_EXEC = 2'b01,
    WDC_ST_TX = 2'b10
  } wdc_state_t;
endpackage
`default_nettype wire

// File: hdl/wdc_tick.sv
// 100 ms step generator, restartable
`timescale 1ns/1ps
`default_nettype none
module wdc_tick #(
  parameter int TICK_CYCLES = 20000000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic restart_in,
  output logic tick_out
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  logic [CW-1:0] cnt;
  // restart keeps the first step after a load a full period long
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= '0;
      tick_out <= 1'b0;
    end else if (restart_in || cnt == CW'(TICK_CYCLES - 1)) begin
      cnt <= '0;
      tick_out <= !restart_in;
    end else begin
      cnt <= cnt + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule // wdc_tick
`default_nettype wire

// File: hdl/wdc_watchdog.sv
// command-driven system watchdog with byte-stream request and response
// Overview of operation
// - unreloaded countdown at zero fires the configured expiry action
// - reload request restarts countdown from initial
// - set request configures and starts the timer
// - use byte: no-log, no-stop, use code
// - action byte bits 6:4 pick pre-timeout interrupt
// - action bits 2:0 pick expiry action
// - pre-timeout raised interval seconds before expiry
// - clear byte ones clear matching expiration flags
// - sixteen-bit initial count, 100 ms per count
// - no-stop set while running keeps counting
// - no-stop set while stopped stays stopped
// - no-stop set clears pending pre-timeout
// - get request returns config and present count
`timescale 1ns/1ps
`default_nettype none
`include "wdc_map.svh"
module wdc_watchdog #(
  parameter int TICK_CYCLES = `WDC_TICK_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire wdc_pkg::wdc_byte_t req_in,
  output logic req_ready_out,
  output var wdc_pkg::wdc_byte_t rsp_out,
  output logic running_out,
  output logic hard_reset_out,
  output logic power_down_out,
  output logic power_cycle_out,
  output logic log_expiry_out,
  output logic pre_smi_out,
  output logic pre_nmi_out,
  output logic pre_msg_out,
  output logic [4:0] expire_flags_out
);
  import wdc_pkg::*;

  localparam logic [15:0] SECS_TICKS = 16'(`WDC_TICKS_PER_S);

  wdc_state_t state;
  wdc_state_t next_state;
  wdc_cfg_t cfg;
  logic [7:0][7:0] rx;
  logic [3:0] idx;
  logic [3:0] rx_len;
  logic [3:0] tx_idx;
  logic [3:0] tx_len;
  logic [7:0] cc;
  logic [7:0] cc_q;
  logic [15:0] count;
  logic [15:0] snap;
  logic running;
  logic pre_pend;
  logic tick;
  logic take;
  logic exec;
  logic do_set;
  logic do_reload;
  logic is_get;
  logic expire;
  logic pre_hit;
  logic new_nostop;
  logic [15:0] new_init;
  logic [4:0] use_hot;

  // response byte at a given position of the get answer
  function automatic logic [7:0] rsp_byte(input logic [3:0] i);
    case (i)
      4'h0: rsp_byte = cc_q;
      4'h1: rsp_byte = {cfg.no_log, cfg.no_stop, 3'h0, cfg.use_code};
      4'h2: rsp_byte = {1'b0, cfg.pre_irq, 1'b0, cfg.action};
      4'h3: rsp_byte = cfg.pre_secs;
      4'h4: rsp_byte = {2'h0, expire_flags_out, 1'b0};
      4'h5: rsp_byte = cfg.init[7:0];
      4'h6: rsp_byte = cfg.init[15:8];
      4'h7: rsp_byte = snap[7:0];
      4'h8: rsp_byte = snap[15:8];
      default: rsp_byte = 8'h00;
    endcase
  endfunction

  wdc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .restart_in(do_set || do_reload),
    .tick_out(tick)
  );

  // request decode; completion code zero only for a well formed request
  always_comb begin
    take = req_in.valid && req_ready_out;
    exec = (state == WDC_ST_EXEC);
    new_nostop = rx[`WDC_B_USE][`WDC_F_NOSTOP];
    new_init = {rx[`WDC_B_HI], rx[`WDC_B_LO]};
    cc = `WDC_CC_BAD_CMD;
    if (rx[0] == `WDC_NETFN_APP) begin
      unique case (rx[1])
        `WDC_CMD_RELOAD: cc = (rx_len == `WDC_LEN_RELOAD) ? `WDC_CC_OK : `WDC_CC_BAD_LEN;
        `WDC_CMD_SET: cc = (rx_len == `WDC_LEN_SET) ? `WDC_CC_OK : `WDC_CC_BAD_LEN;
        `WDC_CMD_GET: cc = (rx_len == `WDC_LEN_GET) ? `WDC_CC_OK : `WDC_CC_BAD_LEN;
        default: cc = `WDC_CC_BAD_CMD;
      endcase
    end
    do_reload = exec && cc == `WDC_CC_OK && rx[1] == `WDC_CMD_RELOAD;
    do_set = exec && cc == `WDC_CC_OK && rx[1] == `WDC_CMD_SET;
    is_get = exec && cc == `WDC_CC_OK && rx[1] == `WDC_CMD_GET;
  end

  // step, expiry and pre-timeout events; only a load owns the cycle, a get must not eat a step
  always_comb begin
    expire = running && tick && !do_set && !do_reload && count <= 16'h0001;
    pre_hit = running && tick && !do_set && !do_reload && count > 16'h0001
      && cfg.pre_secs != 8'h00
      && cfg.pre_irq >= `WDC_PRE_SMI && cfg.pre_irq <= `WDC_PRE_MSG
      && (count - 16'h0001) == 16'(cfg.pre_secs * SECS_TICKS);
    use_hot = 5'h00;
    if (cfg.use_code >= `WDC_USE_MIN && cfg.use_code <= `WDC_USE_MAX) begin
      use_hot[cfg.use_code - `WDC_USE_MIN] = 1'b1;
    end
  end

  // sequencer: collect, execute one cycle, send answer
  always_comb begin
    next_state = state;
    unique case (state)
      WDC_ST_RX: if (take && req_in.last) next_state = WDC_ST_EXEC;
      WDC_ST_EXEC: next_state = WDC_ST_TX;
      WDC_ST_TX: if (tx_idx == tx_len - 4'h1) next_state = WDC_ST_RX;
      default: next_state = WDC_ST_RX;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= WDC_ST_RX;
      req_ready_out <= 1'b0;
    end else begin
      state <= next_state;
      req_ready_out <= (next_state == WDC_ST_RX);
    end
  end

  // request capture; bytes past the longest request are not stored; the length saturates at nine
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx <= '0;
      idx <= 4'h0;
      rx_len <= 4'h0;
    end else if (take) begin
      if (idx < 4'h8) begin
        rx[idx[2:0]] <= req_in.data;
      end
      idx <= req_in.last ? 4'h0 : ((idx == `WDC_LEN_MAX) ? idx : idx + 4'h1);
      if (req_in.last) begin
        rx_len <= (idx == `WDC_LEN_MAX) ? idx : idx + 4'h1;
      end
    end
  end

  // configuration store, written only by an accepted set
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg <= '{default: '0, pre_secs: `WDC_PRE_RST, init: `WDC_INIT_RST};
    end else if (do_set) begin
      cfg.no_log <= rx[`WDC_B_USE][`WDC_F_NOLOG];
      cfg.no_stop <= new_nostop;
      cfg.use_code <= rx[`WDC_B_USE][2:0];
      cfg.pre_irq <= rx[`WDC_B_ACT][`WDC_F_PRE_HI:`WDC_F_PRE_LO];
      cfg.action <= rx[`WDC_B_ACT][2:0];
      cfg.pre_secs <= rx[`WDC_B_PRE];
      cfg.init <= new_init;
    end
  end

  // countdown; a no-stop set never starts a stopped timer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= `WDC_INIT_RST;
      running <= 1'b0;
    end else if (do_set) begin
      count <= new_init;
      running <= running || !new_nostop;
    end else if (do_reload) begin
      count <= cfg.init;
      running <= 1'b1;
    end else if (running && tick) begin
      count <= (count <= 16'h0001) ? 16'h0000 : count - 16'h0001;
      running <= !expire;
    end
  end

  // pre-timeout pending; a hit in the clearing cycle is kept
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_pend <= 1'b0;
    end else begin
      pre_pend <= pre_hit || (pre_pend && !do_set && !do_reload && !expire);
    end
  end

  // expiration flags: clear by set mask, expiry set wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      expire_flags_out <= 5'h00;
    end else begin
      expire_flags_out <= (expire ? use_hot : 5'h00)
        | (expire_flags_out & ~(do_set ? rx[`WDC_B_CLR][`WDC_F_CLR_HI:`WDC_F_CLR_LO]
        : 5'h00));
    end
  end

  // expiry actions as one-cycle pulses; reserved codes do nothing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hard_reset_out <= 1'b0;
      power_down_out <= 1'b0;
      power_cycle_out <= 1'b0;
      log_expiry_out <= 1'b0;
    end else begin
      hard_reset_out <= expire && cfg.action == `WDC_ACT_HARD;
      power_down_out <= expire && cfg.action == `WDC_ACT_DOWN;
      power_cycle_out <= expire && cfg.action == `WDC_ACT_CYCLE;
      log_expiry_out <= expire && !cfg.no_log;
    end
  end

  // status levels, registered for clean outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      running_out <= 1'b0;
      pre_smi_out <= 1'b0;
      pre_nmi_out <= 1'b0;
      pre_msg_out <= 1'b0;
    end else begin
      running_out <= running;
      pre_smi_out <= pre_pend && cfg.pre_irq == `WDC_PRE_SMI;
      pre_nmi_out <= pre_pend && cfg.pre_irq == `WDC_PRE_NMI;
      pre_msg_out <= pre_pend && cfg.pre_irq == `WDC_PRE_MSG;
    end
  end

  // answer stream; count snapshot keeps the reply self-consistent
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_idx <= 4'h0;
      tx_len <= `WDC_RSP_SHORT;
      cc_q <= `WDC_CC_OK;
      snap <= `WDC_INIT_RST;
      rsp_out <= '0;
    end else if (exec) begin
      tx_idx <= 4'h0;
      tx_len <= is_get ? `WDC_RSP_GET : `WDC_RSP_SHORT;
      cc_q <= cc;
      snap <= count;
      rsp_out <= '0;
    end else if (state == WDC_ST_TX) begin
      tx_idx <= tx_idx + 4'h1;
      rsp_out.valid <= 1'b1;
      rsp_out.last <= (tx_idx == tx_len - 4'h1);
      rsp_out.data <= rsp_byte(tx_idx);
    end else begin
      rsp_out <= '0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_exec;
    state == WDC_ST_EXEC;
  endsequence
  sequence s_first_byte;
    ##2 rsp_out.valid && rsp_out.data == $past(cc, 2);
  endsequence

  reload_count_a: assert property (do_reload |=> count == cfg.init && running)
    else $error("reload did not restart countdown");
  set_load_a: assert property (do_set |=> count == $past(new_init))
    else $error("set did not load initial count");
  nostop_run_a: assert property (do_set && new_nostop && running |=> running)
    else $error("no-stop set paused running timer");
  nostop_idle_a: assert property (do_set && new_nostop && !running |=> !running)
    else $error("no-stop set started stopped timer");
  pre_clear_a: assert property (do_set && new_nostop |=> !pre_pend)
    else $error("pending pre-timeout not cleared");
  pre_raise_a: assert property (pre_hit |=> pre_pend ##1 (pre_smi_out || pre_nmi_out
    || pre_msg_out))
    else $error("pre-timeout not raised");
  hard_reset_a: assert property (expire && cfg.action == `WDC_ACT_HARD
    |=> hard_reset_out && !power_down_out && !power_cycle_out ##1 !hard_reset_out)
    else $error("hard reset pulse wrong");
  reserved_act_a: assert property (expire && cfg.action > `WDC_ACT_CYCLE
    |=> !hard_reset_out && !power_down_out && !power_cycle_out)
    else $error("reserved action acted");
  expire_flag_a: assert property (expire && use_hot != 5'h00
    |=> (expire_flags_out & $past(use_hot)) != 5'h00)
    else $error("expiration flag not set");
  cc_first_a: assert property (s_exec |-> s_first_byte)
    else $error("response does not start with completion code");
  get_len_a: assert property (is_get |-> ##2 rsp_out.valid [*8] ##1 rsp_out.last)
    else $error("get answer length wrong");
endmodule // wdc_watchdog
`default_nettype wire
